// [rtl/tmrp_defines.vh]
// Constants for the dual 16-bit timer register block: word indices,
// control field positions, reset values and capture filter length.
// Assumes inclusion by bare name from the timer top module.
`ifndef TMRP_DEFINES_VH
`define TMRP_DEFINES_VH

// ============================================================
// Register word indices (byte address = timer base + 4 * index)
`define TMRP_IDX_CTRL_A   4'h0
`define TMRP_IDX_CTRL_B   4'h1
`define TMRP_IDX_CNT_L    4'h2
`define TMRP_IDX_CNT_H    4'h3
`define TMRP_IDX_CMPA_L   4'h4
`define TMRP_IDX_CMPA_H   4'h5
`define TMRP_IDX_CMPB_L   4'h6
`define TMRP_IDX_CMPB_H   4'h7
`define TMRP_IDX_CAP_L    4'h8
`define TMRP_IDX_CAP_H    4'h9
`define TMRP_IDX_FLAGS    4'hA
`define TMRP_IDX_INT_EN   4'hB

// ============================================================
// Address decode: bit that picks the timer, bits that pick the word
`define TMRP_ADDR_TSEL    6
`define TMRP_ADDR_IDX_HI  5
`define TMRP_ADDR_IDX_LO  2

// ============================================================
// Control register B fields
`define TMRP_B_FILT       7
`define TMRP_B_EDGE       6
`define TMRP_B_WGM_HI     4
`define TMRP_B_WGM_LO     3
`define TMRP_B_CS_HI      2
`define TMRP_B_CS_LO      0
`define TMRP_B_WMASK      8'hDF

// ============================================================
// Flag and enable bit positions
`define TMRP_F_CAP        0
`define TMRP_F_CMPA       1
`define TMRP_F_CMPB       2

// ============================================================
// Reset values
`define TMRP_RST_BYTE     8'h00
`define TMRP_RST_WORD     16'h0000

// ============================================================
// Capture filter: equal samples needed before output changes
`define TMRP_FILT_LEN     4

`endif

// [rtl/tmrp_top.v]
// Dual 16-bit timer/counter with input capture, clock select and
// output compare, reached over an AHB-Lite slave port.
// Assumes pins are synchronous to hclk and a single-master bus.
`timescale 1ns/100ps
`include "tmrp_defines.vh"
`default_nettype none

module tmrp_top #(
  parameter PRE_W = 10
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // Timer pins, bit 0 is timer A, bit 1 is timer B
  input  wire [1:0]  capture_input_pin,
  input  wire [1:0]  external_clock_pin,
  input  wire [1:0]  capture_ack,
  output wire [1:0]  compare_output_pin_a,
  output wire [1:0]  compare_output_pin_b,
  output wire [1:0]  timer_irq
);

  // ============================================================
  // Bus slave state
  reg             busy_q;      // Data phase in progress
  reg             wr_q;        // Latched direction
  reg             tsel_q;      // Latched timer select
  reg  [3:0]      idx_q;       // Latched word index
  reg  [7:0]      temp_q;      // Shared temporary high byte
  reg  [PRE_W-1:0] pre_q;      // Shared free-running prescaler
  wire [15:0]     rd_vec;      // Read byte from each timer
  wire [15:0]     hi_vec;      // High byte to park in temp, per timer
  wire            take;
  wire            wr_go;
  wire            rd_go;
  wire [7:0]      wdat;
  wire            idx_is_lo;
  wire            idx_is_hi;
  wire [7:0]      rd_byte;

  // Size is not checked: only whole-word transfers are used
  assign take    = hsel & hready & htrans[1] & ~busy_q;
  assign wr_go   = busy_q & wr_q;
  assign rd_go   = busy_q & ~wr_q;
  assign wdat    = hwdata[7:0];
  assign rd_byte = tsel_q ? rd_vec[15:8] : rd_vec[7:0];

  // Low halves of the 16-bit pairs sit at even indices 2..8
  assign idx_is_lo = (idx_q == `TMRP_IDX_CNT_L) | (idx_q == `TMRP_IDX_CMPA_L) |
                     (idx_q == `TMRP_IDX_CMPB_L) | (idx_q == `TMRP_IDX_CAP_L);
  assign idx_is_hi = (idx_q == `TMRP_IDX_CNT_H) | (idx_q == `TMRP_IDX_CMPA_H) |
                     (idx_q == `TMRP_IDX_CMPB_H) | (idx_q == `TMRP_IDX_CAP_H);

  // ============================================================
  // Address phase capture and one-wait-state data phase
  // The wait state lets a read always see the previous write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q    <= 1'b0;
      wr_q      <= 1'b0;
      tsel_q    <= 1'b0;
      idx_q     <= 4'h0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;             // Always OKAY
      if (take) begin
        // Latch the request and stall one cycle
        busy_q    <= 1'b1;
        wr_q      <= hwrite;
        tsel_q    <= haddr[`TMRP_ADDR_TSEL];
        idx_q     <= haddr[`TMRP_ADDR_IDX_HI:`TMRP_ADDR_IDX_LO];
        hreadyout <= 1'b0;
      end else if (busy_q) begin
        // Finish: data byte in the low lane, upper bits zero
        busy_q    <= 1'b0;
        hreadyout <= 1'b1;
        if (!wr_q) begin
          hrdata <= {24'h00_0000, rd_byte};
        end
      end
    end
  end

  // ============================================================
  // Shared temporary high byte and prescaler
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_q <= `TMRP_RST_BYTE;
      pre_q  <= {PRE_W{1'b0}};
    end else begin
      pre_q <= pre_q + 1'b1;
      if (wr_go && idx_is_hi) begin
        temp_q <= wdat;
      end else if (rd_go && idx_is_lo) begin
        // Low read parks the matching high byte for the next read
        temp_q <= tsel_q ? hi_vec[15:8] : hi_vec[7:0];
      end
    end
  end

  // ============================================================
  // One timer per loop pass; timer A owns the external clock pin
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_tmr
      localparam [0:0] TID = t;
      reg  [1:0]  ctla_q;        // Waveform mode low bits
      reg  [7:0]  ctlb_q;        // Control register B
      reg  [15:0] cnt_q;         // Counter value
      reg  [15:0] ocra_q;        // Output compare A
      reg  [15:0] ocrb_q;        // Output compare B
      reg  [15:0] icr_q;         // Capture register
      reg  [2:0]  flg_q;         // Capture, compare A, compare B flags
      reg  [2:0]  ien_q;         // Matching interrupt enables
      reg         dir_q;         // Down-count phase in dual-slope modes
      reg         blk_q;         // Compare block after counter write
      reg         pin_q;         // Registered capture pin
      reg  [2:0]  sr_q;          // Older filter samples
      reg         filt_q;        // Filtered capture level
      reg         prev_q;        // Previous capture source level
      reg         ext_q;         // Previous external clock level
      reg         pa_q;          // Compare output A
      reg         pb_q;          // Compare output B
      reg         irq_q;         // Interrupt request
      reg         tick;
      reg  [15:0] top;
      reg         updown;
      reg  [7:0]  rd;
      reg  [7:0]  hi;
      wire        wsel;
      wire [3:0]  mode;
      wire        icr_top;
      wire        src;
      wire        edge_ev;
      wire        cap_ev;
      wire        top_hit;
      wire        hit_a;
      wire        hit_b;
      wire [2:0]  set_f;
      wire [2:0]  clr_f;
      wire [2:0]  cs;

      assign wsel = wr_go & (tsel_q == TID);
      assign mode = {ctlb_q[`TMRP_B_WGM_HI:`TMRP_B_WGM_LO], ctla_q};
      assign cs   = ctlb_q[`TMRP_B_CS_HI:`TMRP_B_CS_LO];

      // Capture defines top in modes 8, 10, 12 and 14
      assign icr_top = mode[3] & ~mode[0];

      // Top value and count sequence from the waveform mode
      always @* begin
        case (mode)
          4'd1, 4'd5:                top = 16'h00FF;
          4'd2, 4'd6:                top = 16'h01FF;
          4'd3, 4'd7:                top = 16'h03FF;
          4'd4, 4'd9, 4'd11, 4'd15:  top = ocra_q;
          4'd8, 4'd10, 4'd12, 4'd14: top = icr_q;
          default:                   top = 16'hFFFF;
        endcase
        updown = (mode == 4'd1) | (mode == 4'd2) | (mode == 4'd3) |
                 (mode[3:2] == 2'b10);
      end

      // Counter tick from the clock select code
      always @* begin
        case (cs)
          3'd1:    tick = 1'b1;
          3'd2:    tick = (pre_q[2:0] == 3'h7);
          3'd3:    tick = (pre_q[5:0] == 6'h3F);
          3'd4:    tick = (pre_q[7:0] == 8'hFF);
          3'd5:    tick = (pre_q[9:0] == 10'h3FF);
          // Timer A: pin level is read whatever its direction
          3'd6:    tick = (t == 0) ? (ext_q & ~external_clock_pin[t])
                                   : (pre_q[3:0] == 4'hF);
          3'd7:    tick = (t == 0) ? (~ext_q & external_clock_pin[t])
                                   : (pre_q[4:0] == 5'h1F);
          default: tick = 1'b0;
        endcase
      end

      // Capture source, edge choice and the mode gate
      assign src     = ctlb_q[`TMRP_B_FILT] ? filt_q : pin_q;
      assign edge_ev = ctlb_q[`TMRP_B_EDGE] ? (src & ~prev_q)
                                            : (~src & prev_q);
      assign cap_ev  = edge_ev & ~icr_top;
      assign top_hit = tick & icr_top & (cnt_q == top);

      // Matches are taken on timer ticks, not while blocked
      assign hit_a = tick & ~blk_q & (cnt_q == ocra_q);
      assign hit_b = tick & ~blk_q & (cnt_q == ocrb_q);

      assign set_f = {hit_b, hit_a, cap_ev | top_hit};
      assign clr_f = ((wsel && idx_q == `TMRP_IDX_FLAGS) ? wdat[2:0] : 3'b000) |
                     {2'b00, capture_ack[t]};

      // Register read mux and the byte parked in temp on low reads
      always @* begin
        rd = 8'h00;
        hi = 8'h00;
        case (idx_q)
          `TMRP_IDX_CTRL_A: rd = {6'h00, ctla_q};
          `TMRP_IDX_CTRL_B: rd = ctlb_q & `TMRP_B_WMASK;
          `TMRP_IDX_CNT_L: begin
            rd = cnt_q[7:0];
            hi = cnt_q[15:8];
          end
          `TMRP_IDX_CMPA_L: begin
            rd = ocra_q[7:0];
            hi = ocra_q[15:8];
          end
          `TMRP_IDX_CMPB_L: begin
            rd = ocrb_q[7:0];
            hi = ocrb_q[15:8];
          end
          `TMRP_IDX_CAP_L: begin
            rd = icr_q[7:0];
            hi = icr_q[15:8];
          end
          `TMRP_IDX_CNT_H, `TMRP_IDX_CMPA_H,
          `TMRP_IDX_CMPB_H, `TMRP_IDX_CAP_H: rd = temp_q;
          `TMRP_IDX_FLAGS:  rd = {5'h00, flg_q};
          `TMRP_IDX_INT_EN: rd = {5'h00, ien_q};
          default:          rd = 8'h00;                         // Unmapped reads zero
        endcase
      end

      // Capture pin sampling and noise filter
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_q  <= 1'b0;
          sr_q   <= 3'b000;
          filt_q <= 1'b0;
          prev_q <= 1'b0;
          ext_q  <= 1'b0;
        end else begin
          pin_q  <= capture_input_pin[t];
          sr_q   <= {sr_q[1:0], pin_q};
          ext_q  <= external_clock_pin[t];
          prev_q <= src;
          // Four equal samples in a row move the filtered level
          if ({sr_q, pin_q} == 4'hF) begin
            filt_q <= 1'b1;
          end else if ({sr_q, pin_q} == 4'h0) begin
            filt_q <= 1'b0;
          end
        end
      end

      // Control, compare and enable registers
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ctla_q <= 2'b00;
          ctlb_q <= `TMRP_RST_BYTE;
          ocra_q <= `TMRP_RST_WORD;
          ocrb_q <= `TMRP_RST_WORD;
          ien_q  <= 3'b000;
        end else if (wsel) begin
          case (idx_q)
            `TMRP_IDX_CTRL_A: ctla_q <= wdat[1:0];
            `TMRP_IDX_CTRL_B: ctlb_q <= wdat & `TMRP_B_WMASK;
            `TMRP_IDX_CMPA_L: ocra_q <= {temp_q, wdat};
            `TMRP_IDX_CMPB_L: ocrb_q <= {temp_q, wdat};
            `TMRP_IDX_INT_EN: ien_q  <= wdat[2:0];
            default:          ien_q  <= ien_q;
          endcase
        end
      end

      // Counter, direction and compare block
      // A bus write wins over a tick in the same cycle
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q <= `TMRP_RST_WORD;
          dir_q <= 1'b0;
          blk_q <= 1'b0;
        end else if (wsel && idx_q == `TMRP_IDX_CNT_L) begin
          cnt_q <= {temp_q, wdat};
          blk_q <= 1'b1;
        end else if (tick) begin
          blk_q <= 1'b0;
          if (!updown) begin
            dir_q <= 1'b0;
            cnt_q <= (cnt_q >= top) ? 16'h0000 : cnt_q + 16'h0001;
          end else if (!dir_q) begin
            // Turn round at top in dual-slope modes
            if (cnt_q >= top) begin
              dir_q <= 1'b1;
              cnt_q <= (top == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end else if (cnt_q == 16'h0000) begin
            dir_q <= 1'b0;
            cnt_q <= 16'h0001;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
      end

      // Capture register, flags, outputs and interrupt request
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          icr_q <= `TMRP_RST_WORD;
          flg_q <= 3'b000;
          pa_q  <= 1'b0;
          pb_q  <= 1'b0;
          irq_q <= 1'b0;
        end else begin
          if (cap_ev) begin
            icr_q <= cnt_q;
          end
          // Set wins over a clear in the same cycle
          flg_q <= (flg_q & ~clr_f) | set_f;
          if (hit_a) begin
            pa_q <= ~pa_q;
          end
          if (hit_b) begin
            pb_q <= ~pb_q;
          end
          irq_q <= |(flg_q & ien_q);
        end
      end

      assign rd_vec[8*t +: 8]         = rd;
      assign hi_vec[8*t +: 8]         = hi;
      assign compare_output_pin_a[t]  = pa_q;
      assign compare_output_pin_b[t]  = pb_q;
      assign timer_irq[t]             = irq_q;
    end
  endgenerate

endmodule

`default_nettype wire

// [verification/tmrp_pin_drv.sv]
// Pin-side partner of the timer block: capture and external clock pins.
// Assumes the caller enters its tasks just after a rising hclk edge.
`timescale 1ns/100ps
`default_nettype none
module tmrp_pin_drv (
  // Clock
  input  wire logic       hclk,
  // Pins toward the timer block
  output var  logic [1:0] capture_input_pin,
  output var  logic [1:0] external_clock_pin
);
  // Both pins idle low at time zero
  initial begin
    capture_input_pin  = 2'b00;
    external_clock_pin = 2'b00;
  end
  // Move one capture pin, then let one edge pass so it is sampled
  task automatic set_cap(input int i, input logic v);
    capture_input_pin[i] <= v;
    @(posedge hclk);
  endtask
  // Whole pulses, two cycles a phase; timer B has no clock pin
  task automatic ext_pulses(input int n);
    repeat (n) begin
      external_clock_pin[0] <= 1'b1;
      repeat (2) @(posedge hclk);
      external_clock_pin[0] <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

// [verification/tmrp_chk.sv]
// Checker for the timer block: bus timing, control readback,
// stopped counters and timer A interrupt masking at the top ports.
// Assumes one master with hready tied to hreadyout.
`timescale 1ns/100ps
`default_nettype none
`include "tmrp_defines.vh"
module tmrp_chk (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Timer outputs
  input wire logic [1:0]  compare_output_pin_a,
  input wire logic [1:0]  compare_output_pin_b,
  input wire logic [1:0]  timer_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Shadow of control B and enables
  logic            take;    // Transfer accepted at this edge
  logic            wr_q;    // Write data phase
  logic            rd_q;    // Read data phase
  logic            t_q;     // Timer addressed
  logic [3:0]      ix_q;    // Word index addressed
  logic [1:0][7:0] ctlb_q;  // Control B, reserved bit masked
  logic [1:0][2:0] ien_q;   // Interrupt enables
  assign take = hsel && hready && htrans[1] && hreadyout;
  // Shadow updates at the same edge the slave stores the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      t_q    <= 1'b0;
      ix_q   <= 4'h0;
      ctlb_q <= 16'h0000;
      ien_q  <= 6'h00;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      if (take) begin
        t_q  <= haddr[`TMRP_ADDR_TSEL];
        ix_q <= haddr[`TMRP_ADDR_IDX_HI:`TMRP_ADDR_IDX_LO];
      end
      if (wr_q && ix_q == `TMRP_IDX_CTRL_B) begin
        ctlb_q[t_q] <= hwdata[7:0] & `TMRP_B_WMASK;
      end
      if (wr_q && ix_q == `TMRP_IDX_INT_EN) begin
        ien_q[t_q] <= hwdata[2:0];
      end
    end
  end
  // ==========================================================
  // Assertions
  a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout) else $error("wait state");
  a_low_cause: assert property (!hreadyout |-> $past(take)) else $error("stray wait");
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_rdata_byte: assert property (hrdata[31:8] == 24'h000000) else $error("upper bits");
  a_ctlb_readback: assert property (rd_q && ix_q == `TMRP_IDX_CTRL_B |=>
    hrdata[7:0] == ctlb_q[t_q]) else $error("control B readback");
  a_stop_pins_a: assert property (ctlb_q[0][2:0] == 3'h0 |=>
    $stable({compare_output_pin_a[0], compare_output_pin_b[0]})) else $error("timer a moved");
  a_stop_pins_b: assert property (ctlb_q[1][2:0] == 3'h0 |=>
    $stable({compare_output_pin_a[1], compare_output_pin_b[1]})) else $error("timer b moved");
  a_irq_masked: assert property ((ien_q[0] == 3'h0)[*2] |=> !timer_irq[0])
    else $error("masked interrupt");
  // Main scenarios
  cover property (take && hwrite);
  cover property ($rose(timer_irq[0]));
  cover property ($changed(compare_output_pin_a[0]));
endmodule
bind tmrp_top tmrp_chk tmrp_chk_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hrdata, .hresp, .compare_output_pin_a, .compare_output_pin_b, .timer_irq
);
`default_nettype wire

// [verification/tb_top.sv]
// Bench for the timer block: registers, clock select, capture, compare.
// Assumes the pin partner and the checker compile before it.
`timescale 1ns/100ps
`default_nettype none
`include "tmrp_defines.vh"
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb_top;
  // ==========================================================
  // Bus, pins and counters
  logic        hclk;         // 100 MHz
  logic        hresetn;      // Active low
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;        // Always a word
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0]  capture_ack;  // Vector taken strobe
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire  [1:0]  capture_input_pin;
  wire  [1:0]  external_clock_pin;
  wire  [1:0]  compare_output_pin_a;
  wire  [1:0]  compare_output_pin_b;
  wire  [1:0]  timer_irq;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          dv [2][8] = '{'{0, 1, 8, 64, 256, 1024, 0, 0}, '{0, 1, 8, 64, 256, 1024, 16, 32}};
  tmrp_top #(.PRE_W(10)) tmrp_top_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .capture_input_pin,
    .external_clock_pin, .capture_ack, .compare_output_pin_a, .compare_output_pin_b, .timer_irq
  );
  tmrp_pin_drv tmrp_pin_drv_inst (.hclk, .capture_input_pin, .external_clock_pin);
  always #5 hclk = ~hclk;
  // Hang guard, well above the prescaler sweep
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Bus tasks; address phase held until hready is seen high
  task automatic bus(input logic w, input logic t, input logic [3:0] ix,
                     input logic [7:0] wd, output logic [7:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {25'h0000000, t, ix, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic t, input logic [3:0] ix, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, t, ix, d, x);
  endtask
  task automatic rc(input logic t, input logic [3:0] ix, input logic [7:0] e, input string nm);
    logic [7:0] v;
    bus(1'b0, t, ix, 8'h00, v);
    `CHK(nm, e, v)
  endtask
  // Pairs: high byte first on write, low byte first on read
  task automatic w16(input logic t, input logic [3:0] lo, input logic [15:0] v);
    wr(t, lo + 4'h1, v[15:8]);
    wr(t, lo, v[7:0]);
  endtask
  task automatic r16(input logic t, input logic [3:0] lo, output logic [15:0] v);
    bus(1'b0, t, lo, 8'h00, v[7:0]);
    bus(1'b0, t, lo + 4'h1, 8'h00, v[15:8]);
  endtask
  task automatic rc16(input logic t, input logic [3:0] lo, input logic [15:0] e, input string nm);
    logic [15:0] v;
    r16(t, lo, v);
    `CHK(nm, e, v)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 1; i < 8; i++) begin
      rc(1'b0, i[3:0], 8'h00, "a reset");
    end
    rc(1'b1, `TMRP_IDX_CTRL_B, 8'h00, "b ctrl reset");
    rc16(1'b1, `TMRP_IDX_CMPA_L, 16'h0000, "b cmp reset");
  endtask
  task automatic t_ctlb;
    for (int t = 0; t < 2; t++) begin
      wr(t[0], `TMRP_IDX_CTRL_B, 8'hE0);
      rc(t[0], `TMRP_IDX_CTRL_B, 8'hC0, "reserved bit");
      wr(t[0], `TMRP_IDX_CTRL_B, 8'h00);
    end
  endtask
  // One temporary byte serves every pair of both timers
  task automatic t_temp;
    w16(1'b0, `TMRP_IDX_CNT_L, 16'h1234);
    rc16(1'b0, `TMRP_IDX_CNT_L, 16'h1234, "count pair");
    wr(1'b0, `TMRP_IDX_CNT_H, 8'h56);
    wr(1'b1, `TMRP_IDX_CMPA_L, 8'h78);
    rc16(1'b1, `TMRP_IDX_CMPA_L, 16'h5678, "shared temp");
    wr(1'b0, 4'hC, 8'hFF);
    rc(1'b0, 4'hC, 8'h00, "unmapped");
  endtask
  // Run exactly four divider periods, so the count is four
  task automatic t_presc;
    for (int t = 0; t < 2; t++) begin
      for (int c = 1; c < (t == 0 ? 6 : 8); c++) begin
        w16(t[0], `TMRP_IDX_CNT_L, 16'h0000);
        wr(t[0], `TMRP_IDX_CTRL_B, c[7:0]);
        repeat (4 * dv[t][c] - 3) @(posedge hclk);
        wr(t[0], `TMRP_IDX_CTRL_B, 8'h00);
        rc16(t[0], `TMRP_IDX_CNT_L, 16'h0004, "divided count");
      end
    end
    // Dual-slope 8-bit mode turns round at 0xFF within four ticks
    w16(1'b0, `TMRP_IDX_CNT_L, 16'h00FE);
    wr(1'b0, `TMRP_IDX_CTRL_A, 8'hFF);
    rc(1'b0, `TMRP_IDX_CTRL_A, 8'h03, "ctrl a width");
    wr(1'b0, `TMRP_IDX_CTRL_A, 8'h01);
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'h01);
    @(posedge hclk);
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'h00);
    wr(1'b0, `TMRP_IDX_CTRL_A, 8'h00);
    rc16(1'b0, `TMRP_IDX_CNT_L, 16'h00FC, "dual slope");
  endtask
  task automatic t_ext;
    for (int e = 6; e < 8; e++) begin
      w16(1'b0, `TMRP_IDX_CNT_L, 16'h0000);
      wr(1'b0, `TMRP_IDX_CTRL_B, e[7:0]);
      tmrp_pin_drv_inst.ext_pulses(3);
      wr(1'b0, `TMRP_IDX_CTRL_B, 8'h00);
      rc16(1'b0, `TMRP_IDX_CNT_L, 16'h0003, "pin count");
    end
  endtask
  // Compare A is passed; the counter write lands on compare B
  task automatic t_compare;
    logic pa;
    logic pb;
    pa = compare_output_pin_a[0];
    pb = compare_output_pin_b[0];
    w16(1'b0, `TMRP_IDX_CMPA_L, 16'h0012);
    w16(1'b0, `TMRP_IDX_CMPB_L, 16'h4000);
    w16(1'b0, `TMRP_IDX_CNT_L, 16'h0010);
    wr(1'b0, `TMRP_IDX_FLAGS, 8'h07);
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'h01);
    repeat (6) @(posedge hclk);
    w16(1'b0, `TMRP_IDX_CNT_L, 16'h4000);
    repeat (4) @(posedge hclk);
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'h00);
    `CHK("pin a", ~pa, compare_output_pin_a[0])
    `CHK("pin b", pb, compare_output_pin_b[0])
    rc(1'b0, `TMRP_IDX_FLAGS, 8'h02, "match flags");
  endtask
  task automatic t_cap_edges;
    // Compare A flag is still set from the compare scenario
    wr(1'b0, `TMRP_IDX_FLAGS, 8'h07);
    w16(1'b0, `TMRP_IDX_CNT_L, 16'h0ABC);
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'h40);
    tmrp_pin_drv_inst.set_cap(0, 1'b1);
    repeat (4) @(posedge hclk);
    rc16(1'b0, `TMRP_IDX_CAP_L, 16'h0ABC, "capture");
    rc(1'b0, `TMRP_IDX_FLAGS, 8'h01, "cap flag");
    wr(1'b0, `TMRP_IDX_INT_EN, 8'h01);
    repeat (3) @(posedge hclk);
    `CHK("irq on", 1'b1, timer_irq[0])
    wr(1'b0, `TMRP_IDX_INT_EN, 8'h00);
    repeat (3) @(posedge hclk);
    `CHK("irq masked", 1'b0, timer_irq[0])
    capture_ack <= 2'b01;
    @(posedge hclk);
    capture_ack <= 2'b00;
    rc(1'b0, `TMRP_IDX_FLAGS, 8'h00, "ack clear");
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'h00);
    tmrp_pin_drv_inst.set_cap(0, 1'b0);
    repeat (4) @(posedge hclk);
    rc(1'b0, `TMRP_IDX_FLAGS, 8'h01, "falling");
    wr(1'b0, `TMRP_IDX_FLAGS, 8'h01);
    tmrp_pin_drv_inst.set_cap(0, 1'b1);
    repeat (4) @(posedge hclk);
    rc(1'b0, `TMRP_IDX_FLAGS, 8'h00, "rise ignored");
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'h58);
    tmrp_pin_drv_inst.set_cap(0, 1'b0);
    tmrp_pin_drv_inst.set_cap(0, 1'b1);
    repeat (4) @(posedge hclk);
    rc(1'b0, `TMRP_IDX_FLAGS, 8'h00, "top mode");
    wr(1'b0, `TMRP_IDX_CTRL_B, 8'hC0);
    tmrp_pin_drv_inst.set_cap(0, 1'b0);
    repeat (8) @(posedge hclk);
    tmrp_pin_drv_inst.set_cap(0, 1'b1);
    repeat (2) @(posedge hclk);
    tmrp_pin_drv_inst.set_cap(0, 1'b0);
    repeat (8) @(posedge hclk);
    rc(1'b0, `TMRP_IDX_FLAGS, 8'h00, "glitch");
  endtask
  // Same stimulus timing with and without the filter
  task automatic t_cap_filter;
    logic [15:0] v [2];
    for (int f = 0; f < 2; f++) begin
      wr(1'b0, `TMRP_IDX_CTRL_B, 8'h00);
      tmrp_pin_drv_inst.set_cap(0, 1'b0);
      repeat (6) @(posedge hclk);
      w16(1'b0, `TMRP_IDX_CNT_L, 16'h0000);
      wr(1'b0, `TMRP_IDX_CTRL_B, (f == 1) ? 8'hC1 : 8'h41);
      tmrp_pin_drv_inst.set_cap(0, 1'b1);
      repeat (12) @(posedge hclk);
      wr(1'b0, `TMRP_IDX_CTRL_B, 8'h00);
      r16(1'b0, `TMRP_IDX_CAP_L, v[f]);
    end
    `CHK("filter delay", 16'h0004, v[1] - v[0])
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    capture_ack = 2'b00;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_ctlb();
    t_temp();
    t_presc();
    t_ext();
    t_compare();
    t_cap_edges();
    t_cap_filter();
    results();
  end
endmodule
`default_nettype wire
